// File: dv/svs_synth_cfg_bench.sv
// self-checking bench for the synth config block
`default_nettype none
`include "svs_map.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  miscompares++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module svs_synth_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import svs_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, remap;
  logic [31:0]       haddr, hwdata, hrdata, v;
  logic [1:0]        htrans, e;
  logic [2:0]        hsize;
  logic [55:0]       ef;
  svs_out_t [3:0]    gen_out;
  int                n_checks, miscompares;
  svs_synth_cfg dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gen_out(gen_out),
    .hp_eight_from_third(remap));
  // one single-word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] o,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {18'h0, o, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, o, d, x);
  endtask : wr
  // mailbox request, then poll until it reads back zero
  task automatic mbox(input logic [31:0] cmd);
    int i;
    wr(`SVS_OFS_MAILBOX, cmd);
    i = 0;
    do begin
      bus(1'b0, `SVS_OFS_MAILBOX, 32'h0, v);
      i++;
    end while (v !== 32'h0 && i < 200);
    `CHK("mailbox", 32'h0, v)
  endtask : mbox
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // watchdog against a hung handshake
  initial begin
    #200us;
    miscompares++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values
    bus(1'b0, `SVS_OFS_DENOM, 32'h0, v);
    `CHK("denom", 32'h1, v)
    bus(1'b0, `SVS_OFS_SETUP, 32'h0, v);
    `CHK("setup", 32'h1, v)
    `CHK("en_rst", 1'b1, gen_out[2].enable)
    // reserved bits, unmapped place, no effect before commit
    wr(`SVS_OFS_SETUP, 32'hffff_ffff);
    bus(1'b0, `SVS_OFS_SETUP, 32'h0, v);
    `CHK("setup_rsv", 32'h71, v)
    wr(`SVS_OFS_SWAP, 32'hffff_ffff);
    bus(1'b0, `SVS_OFS_SWAP, 32'h0, v);
    `CHK("swap_rsv", 32'h1, v)
    `CHK("no_early", 1'b0, remap)
    wr(12'h6ff, 32'h5);
    bus(1'b0, 12'h6ff, 32'h0, v);
    `CHK("unmapped", 32'h0, v)
    wr(`SVS_OFS_MASK, 32'h4);
    // select change sequence for every select code
    for (int s = 0; s < 8; s++) begin
      wr(`SVS_OFS_SETUP, {25'h0, s[2:0], 4'h0});
      mbox(32'h1);
      `CHK("disabled", 1'b0, gen_out[2].enable)
      wr(`SVS_OFS_SETUP, {25'h0, s[2:0], 4'h1});
      mbox(32'h1);
      e = (s < 4) ? s[1:0] : 2'b00;
      `CHK("loop_id", e, gen_out[2].loop_id)
      `CHK("enabled", 1'b1, gen_out[2].enable)
      `CHK("remap1", 1'b1, remap)
      `CHK("unmasked", 1'b0, gen_out[0].loop_id)
    end
    wr(`SVS_OFS_SWAP, 32'h0);
    mbox(32'h1);
    `CHK("remap0", 1'b0, remap)
    // denominator as divisor, including zero
    wr(`SVS_OFS_DENOM, 32'hffff_0003);
    bus(1'b0, `SVS_OFS_DENOM, 32'h0, v);
    `CHK("denom16", 32'h3, v)
    mbox(32'h1);
    ef = `SVS_RST_BASE;
    ef = ef * `SVS_RST_MULT * `SVS_RST_MVAL;
    `CHK("fvco3", ef / 3, gen_out[2].fvco)
    wr(`SVS_OFS_DENOM, 32'h0);
    mbox(32'h1);
    `CHK("fvco0", ef, gen_out[2].fvco)
    // mailbox read restores the committed setup into the page
    wr(`SVS_OFS_SETUP, 32'h0);
    mbox(32'h2);
    bus(1'b0, `SVS_OFS_SETUP, 32'h0, v);
    `CHK("page_load", 32'h71, v)
    wrap_up();
  end
endmodule : svs_synth_cfg_bench
bind svs_synth_cfg svs_synth_cfg_monitor u_mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .gen_out(gen_out),
  .hp_eight_from_third(hp_eight_from_third));
`default_nettype wire

// File: dv/svs_synth_cfg_monitor.sv
// assertions on bus replies, page commit and generator outputs
`default_nettype none
`include "svs_map.svh"
module svs_synth_cfg_monitor (
  input wire logic                    hclk,      // bus clock
  input wire logic                    hresetn,   // async reset, low
  input wire logic                    hsel,      // slave select
  input wire logic [31:0]             haddr,     // byte address
  input wire logic [1:0]              htrans,    // transfer type
  input wire logic                    hwrite,    // write flag
  input wire logic [31:0]             hwdata,    // write data
  input wire logic                    hready,    // bus ready
  input wire logic [31:0]             hrdata,    // read data
  input wire logic                    hreadyout, // slave ready
  input wire logic                    hresp,     // response
  input wire svs_pkg::svs_out_t [3:0] gen_out,   // generator state
  input wire logic                    hp_eight_from_third // remap
);
  timeunit 1ns;
  timeprecision 1ps;
  import svs_pkg::*;
  logic [11:0] ofs;
  logic        ph_wr, ph_rd, commit, swap;
  logic [7:0]  setup, mask;
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ofs   <= 12'h000;
    end else begin
      ph_wr <= hsel && htrans[1] && hready && hwrite;
      ph_rd <= hsel && htrans[1] && hready && !hwrite;
      ofs   <= haddr[13:2];
    end
  end
  // page shadow and commit pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      commit <= 1'b0;
      setup  <= `SVS_RST_SETUP;
      swap   <= 1'b0;
      mask   <= 8'h00;
    end else begin
      commit <= ph_wr && ofs == `SVS_OFS_MAILBOX && hwdata[1:0] == 2'b01;
      if (ph_wr && ofs == `SVS_OFS_SETUP) setup <= hwdata[7:0];
      if (ph_wr && ofs == `SVS_OFS_SWAP) swap <= hwdata[0];
      if (ph_wr && ofs == `SVS_OFS_MASK) mask <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_setup_reserved: assert property (
    ph_rd && ofs == `SVS_OFS_SETUP |->
    hrdata[31:8] == 0 && (hrdata[7:0] & ~`SVS_SETUP_MASK) == 0)
    else $error("setup reserved bits set");
  chk_swap_reserved: assert property (
    ph_rd && ofs == `SVS_OFS_SWAP |->
    hrdata[31:1] == 0) else $error("swap reserved bits set");
  chk_denom_width: assert property (ph_rd && ofs == `SVS_OFS_DENOM |->
    hrdata[31:16] == 0) else $error("denominator wider than 16 bits");
  chk_remap_commit: assert property (commit |=>
    hp_eight_from_third == $past(swap)) else $error("remap not committed");
  chk_loop_commit: assert property (commit && mask[2] |=>
    gen_out[2].loop_id == ($past(setup[6]) ? 2'd0 : $past(setup[5:4])))
    else $error("loop select not committed");
  chk_enable_commit: assert property (commit && mask[2] |=>
    gen_out[2].enable == $past(setup[0])) else $error("enable wrong");
  chk_remap_hold: assert property ($changed(hp_eight_from_third) |->
    $past(commit)) else $error("remap moved without commit");
  chk_enable_hold: assert property ($changed(gen_out[2].enable) |->
    $past(commit)) else $error("enable moved without commit");
  cover property (commit && mask[2] && setup[6]);
  cover property ($rose(hp_eight_from_third));
  cover property ($fell(gen_out[2].enable));
endmodule : svs_synth_cfg_monitor
`default_nettype wire

// File: rtl/svs_map.svh
// register offsets, field positions and reset values for the synth config block
`ifndef SVS_MAP_SVH
`define SVS_MAP_SVH
`define SVS_OFS_BASE      12'h0685
`define SVS_OFS_MULT      12'h0687
`define SVS_OFS_MVAL      12'h068a
`define SVS_OFS_DENOM     12'h068c
`define SVS_OFS_SETUP     12'h0693
`define SVS_OFS_SWAP      12'h0694
`define SVS_OFS_MASK      12'h0680
`define SVS_OFS_MAILBOX   12'h0681
`define SVS_OFS_STATUS    12'h0682
`define SVS_RST_BASE      16'h1f40
`define SVS_RST_MULT      24'h01_7bb0
`define SVS_RST_MVAL      16'h0001
`define SVS_RST_DENOM     16'h0001
`define SVS_RST_SETUP     8'h01
`define SVS_RST_SWAP      8'h00
`define SVS_SETUP_MASK    8'h71
`define SVS_SWAP_MASK     8'h01
`define SVS_EN_BIT        0
`define SVS_SEL_LSB       4
`define SVS_REMAP_BIT     0
`define SVS_MB_WR_BIT     0
`define SVS_MB_RD_BIT     1
`define SVS_NUM_GEN       4
`define SVS_NUM_LOOPS     4
`endif

// File: rtl/svs_pkg.sv
// types for the synth config block
`default_nettype none
package svs_pkg;
  // one generator's committed configuration
  typedef struct packed {
    logic [15:0] base;
    logic [23:0] mult;
    logic [15:0] mval;
    logic [15:0] denom;
    logic [2:0]  loop_sel;
    logic        enable;
  } svs_cfg_t;
  // per-generator outputs: fvco quotient and selected loop
  typedef struct packed {
    logic [55:0] fvco;
    logic [1:0]  loop_id;
    logic        enable;
  } svs_out_t;
  typedef enum logic [1:0] {SVS_IDLE, SVS_DIV, SVS_DONE} svs_state_t;
endpackage : svs_pkg
`default_nettype wire

// File: rtl/svs_synth_cfg.sv
// per-generator vco and source configuration with mailbox commit
//
// Implementation choice: the AHB-Lite slave port.
`include "svs_map.svh"
// Summary of operation
// - 16-bit denominator term, reset one, used as vco divisor
// - vco frequency is base times multiplier times m over denominator
// - bits 6:4 pick the tracking loop; unknown numbers pick the first
// - bit 0 of setup enables generator; setup resets to 0x01
// - mailbox write applies page to all masked generators, reads back 0
// - mailbox read loads the one masked generator into page, reads 0
// - remap bit routes fourth A/B or third C/D dividers to outputs 8-11
`default_nettype none
module svs_synth_cfg (
  input  wire logic                   hclk,       // bus clock 40 MHz
  input  wire logic                   hresetn,    // async reset, low
  input  wire logic                   hsel,       // slave select
  input  wire logic [31:0]            haddr,      // byte address
  input  wire logic [1:0]             htrans,     // transfer type
  input  wire logic                   hwrite,     // write flag
  input  wire logic [2:0]             hsize,      // transfer size
  input  wire logic [31:0]            hwdata,     // write data
  input  wire logic                   hready,     // bus ready in
  output logic      [31:0]            hrdata,     // read data
  output logic                        hreadyout,  // slave ready
  output logic                        hresp,      // always okay
  output wire svs_pkg::svs_out_t [3:0] gen_out,   // per generator state
  output logic                        hp_eight_from_third // remap state
);
  import svs_pkg::*;

  // page registers (bus side, not yet committed)
  svs_cfg_t    page;
  logic [7:0]  page_swap;
  logic [3:0]  mask;
  logic [1:0]  mailbox;
  // committed per-generator state
  svs_cfg_t    gen_cfg [`SVS_NUM_GEN];
  logic        swap_live;
  // divider engine
  svs_state_t  state;
  logic [1:0]  cur;
  logic [55:0] numer;
  logic [55:0] quot;
  logic [55:0] rem;
  logic [5:0]  bit_idx;
  logic [15:0] div_d;

  // captured address phase
  logic        dp_valid;
  logic        dp_write;
  logic [11:0] dp_addr;

  // read-side mask decode results
  logic        gen_valid_rd;
  logic [1:0]  rd_idx;

  // register index as decoded from haddr[13:2]
  // offsets are word indices, so the byte address is four times them;
  // the decoder compares indices and never sees the two low bits
  function automatic logic [11:0] word_addr(input logic [11:0] ofs);
    word_addr = ofs;
  endfunction : word_addr

  // loop select clamp: nonexistent loop maps to the first loop
  function automatic logic [1:0] loop_of(input logic [2:0] sel);
    loop_of = (sel < 3'(`SVS_NUM_LOOPS)) ? sel[1:0] : 2'b00;
  endfunction : loop_of

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr[13:2];
    end
  end

  logic wr_en;
  assign wr_en = dp_valid && dp_write;

  // page register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page.base     <= `SVS_RST_BASE;
      page.mult     <= `SVS_RST_MULT;
      page.mval     <= `SVS_RST_MVAL;
      page.denom    <= `SVS_RST_DENOM;
      page.loop_sel <= 3'b000;
      page.enable   <= 1'b1;
      page_swap     <= `SVS_RST_SWAP;
      mask          <= 4'h0;
    end else if (state == SVS_IDLE && mailbox[`SVS_MB_RD_BIT]
                 && gen_valid_rd) begin
      page <= gen_cfg[rd_idx];
    end else if (wr_en) begin
      // page fields only; nothing here reaches a generator until commit
      if (dp_addr == word_addr(`SVS_OFS_BASE)) begin
        page.base <= hwdata[15:0];
      end
      if (dp_addr == word_addr(`SVS_OFS_MULT)) begin
        page.mult <= hwdata[23:0];
      end
      if (dp_addr == word_addr(`SVS_OFS_MVAL)) begin
        page.mval <= hwdata[15:0];
      end
      if (dp_addr == word_addr(`SVS_OFS_DENOM)) begin
        page.denom <= hwdata[15:0];
      end
      // reserved setup bits are simply not stored
      if (dp_addr == word_addr(`SVS_OFS_SETUP)) begin
        page.loop_sel <= hwdata[`SVS_SEL_LSB +: 3];
        page.enable   <= hwdata[`SVS_EN_BIT];
      end
      if (dp_addr == word_addr(`SVS_OFS_SWAP)) begin
        page_swap <= hwdata[7:0] & `SVS_SWAP_MASK;
      end
      if (dp_addr == word_addr(`SVS_OFS_MASK)) begin
        mask <= hwdata[3:0];
      end
    end
  end

  // note: a page load from a mailbox read overrides a write
  // landing in the same cycle; hosts poll the mailbox first

  // read-side mask decode: exactly one bit set
  // a read with zero or several mask bits loads nothing
  always_comb begin
    gen_valid_rd = 1'b0;
    rd_idx       = 2'd0;
    case (mask)
      4'b0001: begin gen_valid_rd = 1'b1; rd_idx = 2'd0; end
      4'b0010: begin gen_valid_rd = 1'b1; rd_idx = 2'd1; end
      4'b0100: begin gen_valid_rd = 1'b1; rd_idx = 2'd2; end
      4'b1000: begin gen_valid_rd = 1'b1; rd_idx = 2'd3; end
      default: begin gen_valid_rd = 1'b0; rd_idx = 2'd0; end
    endcase
  end

  // mailbox: host sets, device clears when done (set wins over done)
  // read requests finish in one cycle; writes wait for the divider,
  // so the mailbox only reads zero once fvco is valid too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mailbox <= 2'b00;
    end else if (wr_en && dp_addr == word_addr(`SVS_OFS_MAILBOX)) begin
      mailbox <= hwdata[1:0];
    end else if (state == SVS_IDLE && mailbox[`SVS_MB_RD_BIT]) begin
      mailbox <= 2'b00;
    end else if (state == SVS_DONE) begin
      mailbox <= 2'b00;
    end
  end

  // commit: write page into every masked generator, remap goes live
  // the commit lasts one cycle: the engine leaves idle right after,
  // so later page writes cannot leak into a generator
  generate
    for (genvar g = 0; g < `SVS_NUM_GEN; g++) begin : g_gen
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gen_cfg[g] <= '{`SVS_RST_BASE, `SVS_RST_MULT, `SVS_RST_MVAL,
                          `SVS_RST_DENOM, 3'b000, 1'b1};
        end else if (state == SVS_IDLE && mailbox == 2'b01 && mask[g]) begin
          gen_cfg[g] <= page;
        end
      end
      assign gen_out[g].loop_id = loop_of(gen_cfg[g].loop_sel);
      assign gen_out[g].enable  = gen_cfg[g].enable;
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swap_live <= 1'b0;
    end else if (state == SVS_IDLE && mailbox == 2'b01) begin
      swap_live <= page_swap[`SVS_REMAP_BIT];
    end
  end
  assign hp_eight_from_third = swap_live;

  // fvco engine: after commit, divide the page product serially, once for all masked generators
  // restoring division, one quotient bit per cycle, msb first;
  // chosen over a wide divider to keep the area small, at the cost
  // of roughly sixty cycles of mailbox latency per commit
  logic [55:0] fvco_q [`SVS_NUM_GEN];
  logic [55:0] rem_sh;
  assign rem_sh = {rem[54:0], numer[bit_idx]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= SVS_IDLE;
      cur     <= 2'd0;
      numer   <= 56'h0;
      quot    <= 56'h0;
      rem     <= 56'h0;
      bit_idx <= 6'd0;
      div_d   <= 16'h0001;
    end else begin
      case (state)
        SVS_IDLE: begin
          if (mailbox == 2'b01) begin
            state <= SVS_DIV;
            cur   <= 2'd0;
            // operands widened first so the product is not cut short
            numer <= 56'(page.base) * 56'(page.mult)
                     * 56'(page.mval);
            div_d <= (page.denom == 16'h0) ? 16'h0001 : page.denom;
            quot  <= 56'h0;
            rem   <= 56'h0;
            bit_idx <= 6'd55;
          end
        end
        SVS_DIV: begin
          if (rem_sh >= {40'h0, div_d}) begin
            rem  <= rem_sh - {40'h0, div_d};
            quot <= {quot[54:0], 1'b1};
          end else begin
            rem  <= rem_sh;
            quot <= {quot[54:0], 1'b0};
          end
          // last bit done: hand the quotient over next cycle
          if (bit_idx == 6'd0) begin
            state <= SVS_DONE;
          end else begin
            bit_idx <= bit_idx - 6'd1;
          end
        end
        SVS_DONE: state <= SVS_IDLE;
        default:  state <= SVS_IDLE;
      endcase
    end
  end

  // latch quotient into the masked generators
  generate
    for (genvar g = 0; g < `SVS_NUM_GEN; g++) begin : g_fv
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          fvco_q[g] <= 56'h0;
        end else if (state == SVS_DONE && mask[g]) begin
          fvco_q[g] <= quot;
        end
      end
      assign gen_out[g].fvco = fvco_q[g];
    end
  endgenerate

  // read mux, reserved bits as zero
  // registered in the address phase so data stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[13:2])
        word_addr(`SVS_OFS_BASE): begin
          hrdata <= {16'h0, page.base};
        end
        word_addr(`SVS_OFS_MULT): begin
          hrdata <= {8'h0, page.mult};
        end
        word_addr(`SVS_OFS_MVAL): begin
          hrdata <= {16'h0, page.mval};
        end
        word_addr(`SVS_OFS_DENOM): begin
          hrdata <= {16'h0, page.denom};
        end
        word_addr(`SVS_OFS_SETUP): begin
          hrdata <= {24'h0, 1'b0, page.loop_sel, 3'b000, page.enable};
        end
        word_addr(`SVS_OFS_SWAP): begin
          hrdata <= {24'h0, page_swap};
        end
        word_addr(`SVS_OFS_MASK): begin
          hrdata <= {28'h0, mask};
        end
        word_addr(`SVS_OFS_MAILBOX): begin
          hrdata <= {30'h0, mailbox};
        end
        // status: bit 1 engine idle, bit 2 live remap
        word_addr(`SVS_OFS_STATUS): begin
          hrdata <= {29'h0, swap_live, state == SVS_IDLE, 1'b0};
        end
        default:                     hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : svs_synth_cfg
`default_nettype wire
